// ### dbsr_bus_strobe_reset.v
// External bus strobe generator and reset sequencer
//
// Contract
// - During reset, all four strobes are high and the data bus is released.
// - After reset falls, address and program counter clear on the fifth clock edge.
// - After reset release, execution resumes from address zero on the fourth clock edge.
// - Reset passes a synchroniser; response latency may vary by one cycle.
// - At most one strobe is asserted in any cycle.
// - A write hit by reset may carry a corrupted address.
// - Address stays stable while any strobe returns high.
// - Data bus is driven only while a write strobe is low.
// - Port cycles put the port number on low three lines, others low.
`timescale 1ns/1ns
`include "dbsr_map.vh"

module dbsr_bus_strobe_reset #(
    parameter ADDR_W = `DBSR_ADDR_W,
    parameter DATA_W = `DBSR_DATA_W
) (
    input  wire              core_clk_i,
    input  wire              rst_n_i,
    input  wire              reset_in_n_i,
    input  wire              int_in_n_i,
    input  wire              branch_test_in_n_i,
    input  wire [2:0]        req_i,
    input  wire [ADDR_W-1:0] req_addr_i,
    input  wire [2:0]        port_select_i,
    input  wire [DATA_W-1:0] wr_data_i,
    input  wire [DATA_W-1:0] data_bus_i,
    output wire              req_ready_o,
    output reg  [DATA_W-1:0] rd_data_o,
    output reg               rd_valid_o,
    output reg  [ADDR_W-1:0] prog_counter_o,
    output wire              core_run_o,
    output reg               int_sample_n_o,
    output reg               branch_test_sample_n_o,
    output reg  [ADDR_W-1:0] address_outputs_o,
    output reg               mem_read_strobe_n_o,
    output reg               port_read_strobe_n_o,
    output reg               mem_write_strobe_n_o,
    output reg               port_write_strobe_n_o,
    output reg  [DATA_W-1:0] data_bus_o,
    output reg               data_bus_oe_o,
    output reg               cycle_clock_out_o
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
// First stages feed only second stages; reset edge phase shifts latency by a cycle.
reg       rs_meta_reg;
reg       rs_sync_reg;
reg       int_meta_reg;
reg       int_sync_reg;
reg       bio_meta_reg;
reg       bio_sync_reg;

always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rs_meta_reg  <= 1'b0;
        rs_sync_reg  <= 1'b0;
        int_meta_reg <= 1'b1;
        int_sync_reg <= 1'b1;
        bio_meta_reg <= 1'b1;
        bio_sync_reg <= 1'b1;
    end else begin
        rs_meta_reg  <= reset_in_n_i;
        rs_sync_reg  <= rs_meta_reg;
        int_meta_reg <= int_in_n_i;
        int_sync_reg <= int_meta_reg;
        bio_meta_reg <= branch_test_in_n_i;
        bio_sync_reg <= bio_meta_reg;
    end
end

// ----------------------------------------
// Reset sequencer
// ----------------------------------------
localparam [1:0] ST_RESET  = `DBSR_ST_RESET;
localparam [1:0] ST_CLEAR  = `DBSR_ST_CLEAR;
localparam [1:0] ST_RESUME = `DBSR_ST_RESUME;
localparam [1:0] ST_RUN    = `DBSR_ST_RUN;

reg [1:0] state_reg;
reg [1:0] state_next;

always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_RESET:  state_next = ST_CLEAR;
        ST_CLEAR:  if (rs_sync_reg) state_next = ST_RESUME;
        ST_RESUME: state_next = ST_RUN;
        ST_RUN:    state_next = state_reg;
        default:   state_next = ST_RESET;
    endcase
    if (!rs_sync_reg && state_reg != ST_RESET && state_reg != ST_CLEAR)
        state_next = ST_RESET;
end

always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
        state_reg <= ST_RESET;
    else
        state_reg <= state_next;
end

assign core_run_o  = (state_reg == ST_RUN);
assign req_ready_o = core_run_o && rs_sync_reg;

// ----------------------------------------
// Bus cycle engine
// ----------------------------------------
// Each accepted request owns the bus for two cycles, so strobes never overlap.
reg [2:0] req_reg;
reg       phase_reg;

always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        req_reg               <= `DBSR_REQ_NONE;
        phase_reg             <= 1'b0;
        prog_counter_o        <= `DBSR_ADDR_RST;
        address_outputs_o     <= `DBSR_ADDR_RST;
        mem_read_strobe_n_o   <= 1'b1;
        port_read_strobe_n_o  <= 1'b1;
        mem_write_strobe_n_o  <= 1'b1;
        port_write_strobe_n_o <= 1'b1;
        data_bus_o            <= `DBSR_DATA_RST;
        data_bus_oe_o         <= 1'b0;
        rd_data_o             <= `DBSR_DATA_RST;
        rd_valid_o            <= 1'b0;
    end else begin
        rd_valid_o             <= 1'b0;
        if (!rs_sync_reg || state_reg != ST_RUN) begin
            // Strobes high and bus released at once; a write cut short may
            // leave a bad address on the far side.
            mem_read_strobe_n_o   <= 1'b1;
            port_read_strobe_n_o  <= 1'b1;
            mem_write_strobe_n_o  <= 1'b1;
            port_write_strobe_n_o <= 1'b1;
            data_bus_oe_o         <= 1'b0;
            req_reg               <= `DBSR_REQ_NONE;
            phase_reg             <= 1'b0;
            if (state_reg == ST_CLEAR) begin
                address_outputs_o <= `DBSR_ADDR_RST;
                prog_counter_o    <= `DBSR_ADDR_RST;
            end
        end else if (phase_reg) begin
            // Strobe returns high while address is held unchanged.
            // The far side answers our own registered strobes, so the bus
            // is in this domain; a synchroniser here would return stale data.
            if (!mem_read_strobe_n_o || !port_read_strobe_n_o) begin
                rd_data_o  <= data_bus_i;
                rd_valid_o <= 1'b1;
            end
            mem_read_strobe_n_o   <= 1'b1;
            port_read_strobe_n_o  <= 1'b1;
            mem_write_strobe_n_o  <= 1'b1;
            port_write_strobe_n_o <= 1'b1;
            data_bus_oe_o         <= 1'b0;
            if (req_reg == `DBSR_REQ_FETCH)
                prog_counter_o <= prog_counter_o + {{(ADDR_W-1){1'b0}}, 1'b1};
            phase_reg <= 1'b0;
            req_reg   <= `DBSR_REQ_NONE;
        end else if (req_i != `DBSR_REQ_NONE) begin
            req_reg   <= req_i;
            phase_reg <= 1'b1;
            case (req_i)
                `DBSR_REQ_FETCH: begin
                    address_outputs_o   <= prog_counter_o;
                    mem_read_strobe_n_o <= 1'b0;
                end
                `DBSR_REQ_MEM_WR: begin
                    address_outputs_o    <= req_addr_i;
                    mem_write_strobe_n_o <= 1'b0;
                    data_bus_o           <= wr_data_i;
                    data_bus_oe_o        <= 1'b1;
                end
                `DBSR_REQ_PORT_RD: begin
                    address_outputs_o    <= {{(ADDR_W-3){1'b0}}, port_select_i};
                    port_read_strobe_n_o <= 1'b0;
                end
                `DBSR_REQ_PORT_WR: begin
                    address_outputs_o     <= {{(ADDR_W-3){1'b0}}, port_select_i};
                    port_write_strobe_n_o <= 1'b0;
                    data_bus_o            <= wr_data_i;
                    data_bus_oe_o         <= 1'b1;
                end
                default: begin
                    req_reg   <= `DBSR_REQ_NONE;
                    phase_reg <= 1'b0;
                end
            endcase
        end
    end
end

// ----------------------------------------
// Pin sample outputs
// ----------------------------------------
// Sampled copies trail the pins by three edges; a pulse shorter than
// one period may be missed, so the far side must hold the pin longer.
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        int_sample_n_o         <= 1'b1;
        branch_test_sample_n_o <= 1'b1;
    end else begin
        int_sample_n_o         <= int_sync_reg;
        branch_test_sample_n_o <= bio_sync_reg;
    end
end

// ----------------------------------------
// Cycle clock output
// ----------------------------------------
// Registered toggle at half the core rate, so the pin never glitches
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
        cycle_clock_out_o <= 1'b0;
    else
        cycle_clock_out_o <= ~cycle_clock_out_o;
end

endmodule

// ### dbsr_bus_strobe_reset_bench.sv
// Self-checking bench for the bus strobe and reset block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module dbsr_bus_strobe_reset_bench;
    logic        clk = 0, rst_n = 0, rin_n = 1, int_n = 1, bt_n = 1;
    logic [2:0]  req = 0, port = 0;
    logic [15:0] addr = 0, wdat = 0, dbus, rdat, pc, ab, dout;
    logic        rdy, rval, run, is_n, bs_n, mr_n, pr_n, mw_n, pw_n, oe, cco, ck_old;
    int          n_errors = 0, n_compared = 0, cyc = 0;
    dbsr_bus_strobe_reset uut (.core_clk_i(clk), .rst_n_i(rst_n), .reset_in_n_i(rin_n),
        .int_in_n_i(int_n), .branch_test_in_n_i(bt_n), .req_i(req), .req_addr_i(addr),
        .port_select_i(port), .wr_data_i(wdat), .data_bus_i(dbus), .req_ready_o(rdy),
        .rd_data_o(rdat), .rd_valid_o(rval), .prog_counter_o(pc), .core_run_o(run),
        .int_sample_n_o(is_n), .branch_test_sample_n_o(bs_n), .address_outputs_o(ab),
        .mem_read_strobe_n_o(mr_n), .port_read_strobe_n_o(pr_n), .mem_write_strobe_n_o(mw_n),
        .port_write_strobe_n_o(pw_n), .data_bus_o(dout), .data_bus_oe_o(oe),
        .cycle_clock_out_o(cco));
    dbsr_mem_model u_mem (.mem_read_strobe_n_i(mr_n), .port_read_strobe_n_i(pr_n),
        .addr_i(ab), .data_o(dbus));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            report_and_stop;
        end
    end
    task report_and_stop;
        if (n_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Request held two cycles; the second edge falls in the strobe phase and is ignored
    task bus_op(input [2:0] r, input [15:0] a, input [2:0] p, input [15:0] d, input [15:0] ea);
        int k;
        logic [3:0] es;
        logic rd;
        logic wr;
        k = 0;
        rd = (r == 3'h1 || r == 3'h3);
        wr = (r == 3'h2 || r == 3'h4);
        case (r)
            3'h1: es = 4'h7;
            3'h2: es = 4'hd;
            3'h3: es = 4'hb;
            default: es = 4'he;
        endcase
        while (rdy !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        req = r;
        addr = a;
        port = p;
        wdat = d;
        @(negedge clk);
        `CHK("strobes", es, {mr_n, pr_n, mw_n, pw_n})
        `CHK("address", ea, ab)
        `CHK("oe", wr, oe)
        if (wr) `CHK("write data", d, dout)
        @(negedge clk);
        `CHK("strobes idle", 4'hf, {mr_n, pr_n, mw_n, pw_n})
        `CHK("address held", ea, ab)
        `CHK("oe idle", 1'b0, oe)
        `CHK("read valid", rd, rval)
        if (rd) `CHK("read data", ea ^ 16'hc3a5, rdat)
        req = 0;
        @(negedge clk);
    endtask
    task t_pin_reset;
        rin_n = 0;
        repeat (8) @(negedge clk);
        `CHK("reset strobes", 4'hf, {mr_n, pr_n, mw_n, pw_n})
        `CHK("reset oe", 1'b0, oe)
        `CHK("reset address", 16'h0000, ab)
        `CHK("reset counter", 16'h0000, pc)
        `CHK("reset ready", 1'b0, rdy)
        rin_n = 1;
        repeat (8) @(negedge clk);
        `CHK("running", 1'b1, run)
    endtask
    task t_fetch;
        bus_op(3'h1, 16'h0000, 3'h0, 16'h0000, 16'h0000);
        bus_op(3'h1, 16'h0000, 3'h0, 16'h0000, 16'h0001);
        `CHK("counter", 16'h0002, pc)
    endtask
    task t_write;
        bus_op(3'h2, 16'hffff, 3'h0, 16'h5a01, 16'hffff);
        bus_op(3'h2, 16'h8001, 3'h0, 16'ha5fe, 16'h8001);
    endtask
    task t_port;
        for (int p = 0; p < 8; p++) begin
            bus_op(3'h3, 16'hffff, p[2:0], 16'h0000, {13'h0, p[2:0]});
            bus_op(3'h4, 16'hffff, p[2:0], 16'h1234, {13'h0, p[2:0]});
        end
    endtask
    task t_pins;
        int_n = 0;
        bt_n = 0;
        repeat (4) @(negedge clk);
        `CHK("int sample", 2'b00, {is_n, bs_n})
        int_n = 1;
        bt_n = 1;
        repeat (4) @(negedge clk);
        `CHK("int idle", 2'b11, {is_n, bs_n})
        ck_old = cco;
        @(negedge clk);
        `CHK("cycle clock", ~ck_old, cco)
    endtask
    // The address of the interrupted write is left unchecked on purpose
    task t_mid_write;
        rin_n = 0;
        @(negedge clk);
        req = 3'h2;
        addr = 16'h0f0f;
        @(negedge clk);
        req = 0;
        `CHK("cut write strobe", 1'b0, mw_n)
        t_pin_reset;
        bus_op(3'h1, 16'h0000, 3'h0, 16'h0000, 16'h0000);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        t_pin_reset;
        t_fetch;
        t_write;
        t_port;
        t_pins;
        t_mid_write;
        report_and_stop;
    end
endmodule

// ### dbsr_bus_strobe_reset_props.sv
// Assertions on the bus strobe and reset block ports
`timescale 1ns/1ns
module dbsr_bus_strobe_reset_props (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic        reset_in_n_i,
    input wire logic        req_ready_o,
    input wire logic [15:0] prog_counter_o,
    input wire logic [15:0] address_outputs_o,
    input wire logic        mem_read_strobe_n_o,
    input wire logic        port_read_strobe_n_o,
    input wire logic        mem_write_strobe_n_o,
    input wire logic        port_write_strobe_n_o,
    input wire logic        data_bus_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire [3:0] stb_n = {mem_read_strobe_n_o, port_read_strobe_n_o,
                        mem_write_strobe_n_o, port_write_strobe_n_o};
    one_strobe_a: assert property ($onehot0(~stb_n))
        else $error("two strobes low");
    reset_quiet_a: assert property (
        !reset_in_n_i [*4] |-> stb_n == 4'hf && !data_bus_oe_o) else $error("bus active");
    addr_clear_a: assert property (
        !reset_in_n_i [*6] |-> address_outputs_o == 16'h0000 && prog_counter_o == 16'h0000)
        else $error("address not cleared");
    bus_release_a: assert property (data_bus_oe_o |-> !(&stb_n[1:0]))
        else $error("bus driven outside write");
    addr_hold_a: assert property (
        stb_n != 4'hf && reset_in_n_i |=> $stable(address_outputs_o)) else $error("addr moved");
    port_addr_a: assert property (
        !(port_read_strobe_n_o && port_write_strobe_n_o) |-> address_outputs_o[15:3] == 13'h0)
        else $error("port address high bits set");
    resume_run_a: assert property (
        $rose(reset_in_n_i) |-> !req_ready_o ##[1:6] req_ready_o) else $error("no resume");
    read_pulse_a: assert property (
        $fell(port_read_strobe_n_o) |-> !data_bus_oe_o ##1 port_read_strobe_n_o)
        else $error("bad read pulse");
    cover property ($fell(mem_write_strobe_n_o));
    cover property ($fell(port_read_strobe_n_o));
    cover property ($rose(reset_in_n_i));
endmodule
bind dbsr_bus_strobe_reset dbsr_bus_strobe_reset_props u_props (.core_clk_i, .rst_n_i,
    .reset_in_n_i, .req_ready_o, .prog_counter_o, .address_outputs_o, .mem_read_strobe_n_o,
    .port_read_strobe_n_o, .mem_write_strobe_n_o, .port_write_strobe_n_o, .data_bus_oe_o);

// ### dbsr_map.vh
// Constants for the bus strobe and reset control block
`ifndef DBSR_MAP_VH
`define DBSR_MAP_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DBSR_ADDR_W        16
`define DBSR_DATA_W        16
`define DBSR_PORT_W        3

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define DBSR_ADDR_RST      16'h0000
`define DBSR_DATA_RST      16'h0000
`define DBSR_RST_MIN_CYC   5
`define DBSR_RESUME_CYC    1

// ----------------------------------------
// Request codes on the user side
// ----------------------------------------
`define DBSR_REQ_NONE      3'h0
`define DBSR_REQ_FETCH     3'h1
`define DBSR_REQ_MEM_WR    3'h2
`define DBSR_REQ_PORT_RD   3'h3
`define DBSR_REQ_PORT_WR   3'h4

// ----------------------------------------
// Phase states
// ----------------------------------------
`define DBSR_ST_RESET      2'h0
`define DBSR_ST_CLEAR      2'h1
`define DBSR_ST_RESUME     2'h2
`define DBSR_ST_RUN        2'h3

`endif

// ### dbsr_mem_model.sv
// Memory and peripheral model on the far side of the bus
`timescale 1ns/1ns
module dbsr_mem_model (
    input  wire logic        mem_read_strobe_n_i,
    input  wire logic        port_read_strobe_n_i,
    input  wire logic [15:0] addr_i,
    output logic      [15:0] data_o
);
    // Released bus shows the inverse so stale data never passes as a match
    always @* begin
        if (!mem_read_strobe_n_i || !port_read_strobe_n_i) data_o = addr_i ^ 16'hc3a5;
        else data_o = ~(addr_i ^ 16'hc3a5);
    end
endmodule
